// ==== core/cfgpd_pkg.sv ====
// package: constants and types for the configuration word and power-down block
// Summary of operation
// - config word sits at word 3FC; only the external programmer writes it.
// - blank word reads 3FFF; every field takes its all-ones meaning.
// - bit 13 low protects program memory from external reads.
// - protection with re-use bit high covers only the first half.
// - protection with re-use bit low covers all but reserved top words.
// - bits 11-10 choose low-voltage reset and detect levels or disable.
// - bit 9 picks fast internal RC (0) or fast crystal (1).
// - bit 8 picks slow (0) or fast (1) clock after any reset.
// - bit 7 enables pin reset else pin is I/O; bit 6 watchdog reset.
// - bit 5 picks 4 or 8 MHz fast RC when divider select is 10.
// - sleep instruction or any write to trigger register enters power-down.
// - in power-down the fast clock halts; timers run only if enabled before entry.
// - power-down ends on reset, enabled interrupts, or low wake pins.
// - system clock select resets to 0 when start-up bit high, else 1.
// - idle mode stops fetch; only slow timer, wakeup timer and watchdog run.
// - stop mode with slow clock and wakeup irq off halts both oscillators.
package cfgpd_pkg;
  localparam int          CW_W         = 14;
  localparam int          PM_AW        = 10;
  localparam logic [9:0]  CFG_ADDR     = 10'h3FC;
  localparam logic [9:0]  RSV_FIRST    = 10'h3FC;
  localparam logic [9:0]  HALF_ADDR    = 10'h200;
  localparam logic [13:0] CFG_BLANK    = 14'h3FFF;
  localparam logic [13:0] PROT_DATA    = 14'h0000;
  localparam int          B_PROT       = 13;
  localparam int          B_REUSE      = 12;
  localparam int          B_LV_HI      = 11;
  localparam int          B_LV_LO      = 10;
  localparam int          B_FAST_CLOCK_TYPE       = 9;
  localparam int          B_START      = 8;
  localparam int          B_XRST       = 7;
  localparam int          B_WATCHDOG_RESET_EN       = 6;
  localparam int          B_FRC        = 5;
  localparam logic [1:0]  LV_HIGH      = 2'h0;
  localparam logic [1:0]  LV_MID       = 2'h1;
  localparam logic [1:0]  LV_OFF       = 2'h2;
  localparam logic [1:0]  LV_LOW       = 2'h3;
  localparam logic [1:0]  FRC_DIV_SEL  = 2'h2;
  localparam int          FRC_SLOW_MHZ = 4;
  localparam int          FRC_FAST_MHZ = 8;
  // register map, index times four gives the byte address
  localparam logic [7:0]  IDX_PDTRIG   = 8'h03;
  localparam logic [7:0]  IDX_STATUS   = 8'h04;
  localparam logic [7:0]  IDX_CTRL     = 8'h05;
  localparam logic [7:0]  IDX_CFG      = 8'h06;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  localparam int          C_SLOW_CLOCK_ENABLE     = 0;
  localparam int          C_WAKEUP_IRQ_ENABLE      = 1;
  localparam int          C_WDTEN      = 2;

  typedef enum logic [1:0] {CFGPD_RUN, CFGPD_IDLE, CFGPD_STOP} cfgpd_mode_t;

  typedef struct packed {
    logic       protect_en;
    logic       reuse_off;
    logic [1:0] lv_mode;
    logic       low_voltage_reset;
    logic       low_voltage_detect;
    logic       fast_clock_type;
    logic       startup_speed_sel;
    logic       ext_pin_reset_en;
    logic       watchdog_reset_en;
    logic       fast_internal_rc;
  } cfgpd_dec_t;
endpackage

// ==== core/cfgpd_top.sv ====
// module: config word decoder, read protection and power-down control
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps
module cfgpd_top (
  input  wire logic        I_CLOCK,
  input  wire logic        I_RST_N,
  // axi4-lite slave
  input  wire logic [31:0] I_AWADDR,
  input  wire logic        I_AWVALID,
  output logic             O_AWREADY,
  input  wire logic [31:0] I_WDATA,
  input  wire logic [3:0]  I_WSTRB,
  input  wire logic        I_WVALID,
  output logic             O_WREADY,
  output logic [1:0]       O_BRESP,
  output logic             O_BVALID,
  input  wire logic        I_BREADY,
  input  wire logic [31:0] I_ARADDR,
  input  wire logic        I_ARVALID,
  output logic             O_ARREADY,
  output logic [31:0]      O_RDATA,
  output logic [1:0]       O_RRESP,
  output logic             O_RVALID,
  input  wire logic        I_RREADY,
  // external programmer port, the only writer of the config word
  input  wire logic        I_PGM_WE,
  input  wire logic [9:0]  I_PGM_ADDR,
  input  wire logic [13:0] I_PGM_WDATA,
  input  wire logic [9:0]  I_EXT_RADDR,
  input  wire logic [13:0] I_EXT_RDATA_RAW,
  output logic [13:0]      O_EXT_RDATA,
  // cpu and wake sources
  input  wire logic        I_SLEEP,
  input  wire logic [1:0]  I_FAST_RC_DIVIDER_SEL,
  input  wire logic        I_EXT_IRQ,
  input  wire logic        I_WKT_IRQ,
  input  wire logic        I_SLOW_TIMER_IRQ,
  input  wire logic        I_SLOW_TIMER_CLOCK_SEL,
  input  wire logic [5:0]  I_PA_WAKE_N,
  input  wire logic [2:0]  I_PB_WAKE_N,
  // decoded configuration
  output logic             O_PROTECT_EN,
  output logic             O_LOW_VOLTAGE_RESET,
  output logic             O_LOW_VOLTAGE_DETECT,
  output logic [1:0]       O_LV_LEVEL,
  output logic             O_FAST_CLOCK_TYPE,
  output logic             O_STARTUP_SPEED_SEL,
  output logic             O_EXT_PIN_RESET_EN,
  output logic             O_WATCHDOG_RESET_EN,
  output logic             O_FAST_RC_8MHZ,
  output logic             O_SYSTEM_CLOCK_SEL,
  // power-down state
  output logic             O_CPU_HALT,
  output logic             O_FAST_OSC_EN,
  output logic             O_SLOW_OSC_EN,
  output logic             O_WAKEUP_TIMER_RUN,
  output logic             O_WATCHDOG_RUN,
  output logic             O_SLOW_TIMER_RUN
);
  // one-time word: blank at power-up, kept through every later reset
  logic [13:0]             config_word = cfgpd_pkg::CFG_BLANK;
  logic [13:0]             cw_latched;
  cfgpd_pkg::cfgpd_dec_t   dec;
  cfgpd_pkg::cfgpd_mode_t  mode;
  cfgpd_pkg::cfgpd_mode_t  next_mode;
  logic [2:0]              ctrl;
  logic                    system_clock_sel;
  logic                    rst_seen;
  logic [8:0]              wake_s1;
  logic [8:0]              wake_s2;
  logic [2:0]              irq_s1;
  logic [2:0]              irq_s2;
  logic                    aw_got;
  logic                    w_got;
  logic [7:0]              aw_idx;
  logic [3:0]              w_strb;
  logic [31:0]             w_data;
  logic                    bvalid;
  logic [1:0]              bresp;
  logic                    rvalid;
  logic [31:0]             rdata;
  logic [1:0]              rresp;

  // programmer port only
  // no reset branch: a reset must not undo protection or options
  always_ff @(posedge I_CLOCK) begin
    if (I_PGM_WE && I_PGM_ADDR == cfgpd_pkg::CFG_ADDR) begin
      config_word <= config_word & I_PGM_WDATA; // otp: bits only clear
    end
  end

  // config is sampled at reset release so fields hold steady while running
  // blank word decodes as all ones
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      cw_latched <= cfgpd_pkg::CFG_BLANK;
      rst_seen   <= 1'b1;
    end else begin
      rst_seen <= 1'b0;
      if (rst_seen) begin
        cw_latched <= config_word;
      end
    end
  end

  wire [1:0] lv_sel = cw_latched[cfgpd_pkg::B_LV_HI:cfgpd_pkg::B_LV_LO];
  assign dec.protect_en         = ~cw_latched[cfgpd_pkg::B_PROT];
  assign dec.reuse_off          = cw_latched[cfgpd_pkg::B_REUSE];
  assign dec.lv_mode            = lv_sel;
  assign dec.low_voltage_reset  = (lv_sel != cfgpd_pkg::LV_OFF);
  assign dec.low_voltage_detect = (lv_sel == cfgpd_pkg::LV_HIGH) ||
                                  (lv_sel == cfgpd_pkg::LV_MID);
  assign dec.fast_clock_type    = cw_latched[cfgpd_pkg::B_FAST_CLOCK_TYPE];
  assign dec.startup_speed_sel  = cw_latched[cfgpd_pkg::B_START];
  assign dec.ext_pin_reset_en   = cw_latched[cfgpd_pkg::B_XRST];
  assign dec.watchdog_reset_en  = cw_latched[cfgpd_pkg::B_WATCHDOG_RESET_EN];
  assign dec.fast_internal_rc   = cw_latched[cfgpd_pkg::B_FRC];

  // protected reads return fixed data
  // protection uses the live word so programming takes effect at once
  wire prot_live  = ~config_word[cfgpd_pkg::B_PROT];
  wire reuse_live = config_word[cfgpd_pkg::B_REUSE];
  wire in_half    = (I_EXT_RADDR < cfgpd_pkg::HALF_ADDR);
  wire in_full    = (I_EXT_RADDR < cfgpd_pkg::RSV_FIRST);
  wire rd_blocked = prot_live && (reuse_live ? in_half : in_full);

  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      O_EXT_RDATA <= cfgpd_pkg::PROT_DATA;
    end else if (I_EXT_RADDR == cfgpd_pkg::CFG_ADDR) begin
      O_EXT_RDATA <= config_word;
    end else begin
      O_EXT_RDATA <= rd_blocked ? cfgpd_pkg::PROT_DATA : I_EXT_RDATA_RAW;
    end
  end

  // clock select reset value from start-up bit
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N || rst_seen) begin
      system_clock_sel <= ~config_word[cfgpd_pkg::B_START];
    end else begin
      system_clock_sel <= system_clock_sel;
    end
  end

  // pin and interrupt inputs cross into the clock domain
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      wake_s1 <= 9'h1FF;
      wake_s2 <= 9'h1FF;
      irq_s1  <= 3'h0;
      irq_s2  <= 3'h0;
    end else begin
      wake_s1 <= {I_PB_WAKE_N, I_PA_WAKE_N};
      wake_s2 <= wake_s1;
      irq_s1  <= {I_SLOW_TIMER_IRQ, I_WKT_IRQ, I_EXT_IRQ};
      irq_s2  <= irq_s1;
    end
  end

  // axi write channel: both halves may arrive in any order
  wire wr_fire   = aw_got && w_got && !bvalid;
  wire wr_pdtrig = wr_fire && aw_idx == cfgpd_pkg::IDX_PDTRIG;
  wire wr_ctrl   = wr_fire && aw_idx == cfgpd_pkg::IDX_CTRL;
  wire wr_ok     = (aw_idx == cfgpd_pkg::IDX_PDTRIG) ||
                   (aw_idx == cfgpd_pkg::IDX_CTRL);
  assign O_AWREADY = !aw_got;
  assign O_WREADY  = !w_got;
  assign O_BVALID  = bvalid;
  assign O_BRESP   = bresp;

  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      aw_got <= 1'b0;
      w_got  <= 1'b0;
      aw_idx <= 8'h00;
      w_strb <= 4'h0;
      w_data <= 32'h0;
      bvalid <= 1'b0;
      bresp  <= cfgpd_pkg::RESP_OKAY;
    end else begin
      if (I_AWVALID && !aw_got) begin
        aw_got <= 1'b1;
        aw_idx <= I_AWADDR[9:2];
      end
      if (I_WVALID && !w_got) begin
        w_got  <= 1'b1;
        w_strb <= I_WSTRB;
        w_data <= I_WDATA;
      end
      if (wr_fire) begin
        bvalid <= 1'b1;
        bresp  <= wr_ok ? cfgpd_pkg::RESP_OKAY : cfgpd_pkg::RESP_SLVERR;
      end else if (bvalid && I_BREADY) begin
        bvalid <= 1'b0;
        aw_got <= 1'b0;
        w_got  <= 1'b0;
      end
    end
  end

  // firmware power-down settings, low byte only
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      ctrl <= 3'h1; // slow clock enabled after reset
    end else if (wr_ctrl && w_strb[0]) begin
      ctrl <= w_data[2:0];
    end
  end

  // axi read channel, one cycle after address
  wire [31:0] rd_mux =
    (I_ARADDR[9:2] == cfgpd_pkg::IDX_STATUS) ?
      {28'h0, system_clock_sel, O_CPU_HALT, mode} :
    (I_ARADDR[9:2] == cfgpd_pkg::IDX_CTRL)   ? {29'h0, ctrl} :
    (I_ARADDR[9:2] == cfgpd_pkg::IDX_CFG)    ? {18'h0, cw_latched} :
    32'h0;
  wire rd_ok = (I_ARADDR[9:2] == cfgpd_pkg::IDX_STATUS) ||
               (I_ARADDR[9:2] == cfgpd_pkg::IDX_CTRL) ||
               (I_ARADDR[9:2] == cfgpd_pkg::IDX_CFG);
  assign O_ARREADY = !rvalid;
  assign O_RVALID  = rvalid;
  assign O_RDATA   = rdata;
  assign O_RRESP   = rresp;

  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0;
      rresp  <= cfgpd_pkg::RESP_OKAY;
    end else if (I_ARVALID && !rvalid) begin
      rvalid <= 1'b1;
      rdata  <= rd_mux;
      rresp  <= rd_ok ? cfgpd_pkg::RESP_OKAY : cfgpd_pkg::RESP_SLVERR;
    end else if (rvalid && I_RREADY) begin
      rvalid <= 1'b0;
    end
  end

  // wake sources, wakeup and slow timer interrupts gated by their enables, external interrupt ungated
  wire wake_pin = ~&wake_s2;
  wire wake_irq = irq_s2[0] || (irq_s2[1] && ctrl[cfgpd_pkg::C_WAKEUP_IRQ_ENABLE]) ||
                  (irq_s2[2] && ctrl[cfgpd_pkg::C_SLOW_CLOCK_ENABLE]);
  wire wake     = wake_pin || wake_irq;
  wire pd_req   = I_SLEEP || wr_pdtrig;
  // stop when slow clock and wakeup irq off
  wire go_stop  = !ctrl[cfgpd_pkg::C_SLOW_CLOCK_ENABLE] && !ctrl[cfgpd_pkg::C_WAKEUP_IRQ_ENABLE];

  // an entry request in run is taken even with a wake in the same cycle
  always_comb begin
    next_mode = mode;
    unique case (mode)
      cfgpd_pkg::CFGPD_RUN: begin
        if (pd_req) begin
          next_mode = go_stop ? cfgpd_pkg::CFGPD_STOP : cfgpd_pkg::CFGPD_IDLE;
        end
      end
      cfgpd_pkg::CFGPD_IDLE,
      cfgpd_pkg::CFGPD_STOP: begin
        if (wake) begin
          next_mode = cfgpd_pkg::CFGPD_RUN;
        end
      end
      default: next_mode = cfgpd_pkg::CFGPD_RUN;
    endcase
  end

  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      mode <= cfgpd_pkg::CFGPD_RUN;
    end else begin
      mode <= next_mode;
    end
  end

  // idle keeps only enabled slow timer, wakeup timer and watchdog
  wire pd   = (mode != cfgpd_pkg::CFGPD_RUN);
  wire stop = (mode == cfgpd_pkg::CFGPD_STOP);
  assign O_CPU_HALT         = pd;
  assign O_FAST_OSC_EN      = !pd;
  assign O_SLOW_OSC_EN      = !stop && (ctrl[cfgpd_pkg::C_SLOW_CLOCK_ENABLE] ||
                              ctrl[cfgpd_pkg::C_WAKEUP_IRQ_ENABLE] || system_clock_sel);
  assign O_WAKEUP_TIMER_RUN = !stop && ctrl[cfgpd_pkg::C_WAKEUP_IRQ_ENABLE];
  assign O_WATCHDOG_RUN     = !stop && ctrl[cfgpd_pkg::C_WDTEN];
  assign O_SLOW_TIMER_RUN   = pd ? (ctrl[cfgpd_pkg::C_SLOW_CLOCK_ENABLE] && !stop &&
                              !I_SLOW_TIMER_CLOCK_SEL) : 1'b1;

  // decoded fields leave through the struct
  assign O_PROTECT_EN         = dec.protect_en;
  assign O_LOW_VOLTAGE_RESET  = dec.low_voltage_reset;
  assign O_LOW_VOLTAGE_DETECT = dec.low_voltage_detect;
  assign O_LV_LEVEL           = dec.lv_mode;
  assign O_FAST_CLOCK_TYPE    = dec.fast_clock_type;
  assign O_STARTUP_SPEED_SEL  = dec.startup_speed_sel;
  assign O_EXT_PIN_RESET_EN   = dec.ext_pin_reset_en;
  assign O_WATCHDOG_RESET_EN  = dec.watchdog_reset_en;
  // 8 MHz only with divider select 10 and bit 5 set
  assign O_FAST_RC_8MHZ       = dec.fast_internal_rc &&
                  (I_FAST_RC_DIVIDER_SEL == cfgpd_pkg::FRC_DIV_SEL);
  assign O_SYSTEM_CLOCK_SEL   = system_clock_sel;
endmodule

// ==== bench/cfgpd_props.sv ====
// checker: port-level properties of the config word and power-down block
`timescale 1ns/1ps
module cfgpd_props (
  input wire logic        I_CLOCK,
  input wire logic        I_RST_N,
  input wire logic [31:0] I_ARADDR,
  input wire logic        I_ARVALID,
  input wire logic        O_ARREADY,
  input wire logic [31:0] O_RDATA,
  input wire logic [1:0]  O_RRESP,
  input wire logic        O_RVALID,
  input wire logic        I_SLEEP,
  input wire logic [1:0]  I_FAST_RC_DIVIDER_SEL,
  input wire logic        I_EXT_IRQ,
  input wire logic        I_WKT_IRQ,
  input wire logic        I_SLOW_TIMER_IRQ,
  input wire logic [5:0]  I_PA_WAKE_N,
  input wire logic [2:0]  I_PB_WAKE_N,
  input wire logic        O_STARTUP_SPEED_SEL,
  input wire logic        O_FAST_RC_8MHZ,
  input wire logic        O_SYSTEM_CLOCK_SEL,
  input wire logic        O_CPU_HALT,
  input wire logic        O_FAST_OSC_EN,
  input wire logic        O_SLOW_OSC_EN,
  input wire logic        O_WAKEUP_TIMER_RUN,
  input wire logic        O_SLOW_TIMER_RUN
);
  // wake sources; a quiet run of cycles must leave the core asleep
  wire pins_low = !(&{I_PA_WAKE_N, I_PB_WAKE_N});
  wire quiet    = !I_EXT_IRQ && !I_WKT_IRQ && !I_SLOW_TIMER_IRQ && !pins_low;
  wire unmapped = !(I_ARADDR inside {32'hC, 32'h10, 32'h14, 32'h18});
  default clocking dc @(posedge I_CLOCK); endclocking
  default disable iff (!I_RST_N);
  property p_unmapped;
    I_ARVALID && O_ARREADY && unmapped |=>
      O_RVALID && O_RRESP == cfgpd_pkg::RESP_SLVERR && O_RDATA == 32'h0;
  endproperty
  property p_sleep;
    I_SLEEP && !O_CPU_HALT && quiet |=> O_CPU_HALT;
  endproperty
  property p_halt_clk;
    O_CPU_HALT |-> !O_FAST_OSC_EN;
  endproperty
  property p_stop;
    O_CPU_HALT && !O_SLOW_OSC_EN |-> !O_WAKEUP_TIMER_RUN && !O_SLOW_TIMER_RUN;
  endproperty
  property p_irq_wake;
    O_CPU_HALT && I_EXT_IRQ |-> ##[1:4] !O_CPU_HALT;
  endproperty
  property p_pin_wake;
    O_CPU_HALT && pins_low |-> ##[1:4] !O_CPU_HALT;
  endproperty
  property p_stay;
    (O_CPU_HALT && quiet) [*4] |=> O_CPU_HALT;
  endproperty
  property p_sysclk;
    $rose(I_RST_N) |=> O_SYSTEM_CLOCK_SEL == !O_STARTUP_SPEED_SEL;
  endproperty
  property p_frc;
    !$rose(I_RST_N) && O_FAST_RC_8MHZ |->
      I_FAST_RC_DIVIDER_SEL == cfgpd_pkg::FRC_DIV_SEL;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  a_sleep: assert property (p_sleep) else $error("no halt");
  a_halt_clk: assert property (p_halt_clk) else $error("clk on");
  a_stop: assert property (p_stop) else $error("timer in stop");
  a_irq_wake: assert property (p_irq_wake) else $error("irq");
  a_pin_wake: assert property (p_pin_wake) else $error("pin");
  a_stay: assert property (p_stay) else $error("woke idle");
  a_sysclk: assert property (p_sysclk) else $error("clk sel");
  a_frc: assert property (p_frc) else $error("rc freq");
  c_idle: cover property (I_SLEEP ##1 O_CPU_HALT && O_SLOW_OSC_EN);
  c_stop: cover property (O_CPU_HALT && !O_SLOW_OSC_EN);
  c_err: cover property (O_RVALID && O_RRESP == cfgpd_pkg::RESP_SLVERR);
endmodule

bind cfgpd_top cfgpd_props u_props (.*);

// ==== bench/cfgpd_prog_model.sv ====
// partner: program memory image and external programmer
`timescale 1ns/1ps
module cfgpd_prog_model (
  input  wire logic        i_clock,
  input  wire logic [9:0]  i_raddr,
  output logic [13:0]      o_rdata,
  output logic             o_we,
  output logic [9:0]       o_addr,
  output logic [13:0]      o_wdata
);
  // vectors at second half
  // each word carries its own address, so a swapped read shows at once
  assign o_rdata = {4'hA, i_raddr};
  // one-cycle strobe; released lines flip so late sampling cannot match
  task burn(input logic [9:0] a, input logic [13:0] d);
    @(posedge i_clock);
    o_we    <= 1'b1;
    o_addr  <= a;
    o_wdata <= d;
    @(posedge i_clock);
    o_we    <= 1'b0;
    o_addr  <= ~a;
    o_wdata <= ~d;
  endtask
  initial begin
    {o_we, o_addr, o_wdata} = '0;
  end
endmodule

// ==== bench/cfgpd_top_tb.sv ====
// testbench: register, programmer and power-down checks of the block
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
  failures++; $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module cfgpd_top_tb;
  localparam logic [1:0] OK = cfgpd_pkg::RESP_OKAY;
  localparam logic [1:0] ER = cfgpd_pkg::RESP_SLVERR;
  // per power-down pass: ctrl value, status, disabled irqs {wkt, slow}
  localparam logic [2:0] PD_CTRL [5] = '{3'h1, 3'h0, 3'h0, 3'h6, 3'h1};
  localparam logic [3:0] PD_STAT [5] = '{4'h5, 4'h6, 4'h6, 4'h5, 4'h5};
  localparam logic [1:0] PD_DIS  [5] = '{2'h2, 2'h3, 2'h3, 2'h1, 2'h2};
  // expected {fast osc, slow osc, wakeup timer, watchdog, slow timer}
  localparam logic [4:0] PD_RUN  [5] = '{5'h08, 5'h00, 5'h00, 5'h0E, 5'h09};
  logic        clk, rst_n, awv, wv, bready, arv, rready, sleep, ext_irq;
  logic        wkt_irq, st_irq, stcs;
  logic [31:0] awaddr, wdata, araddr;
  logic [1:0]  divsel;
  logic [5:0]  pa_n;
  logic [2:0]  pb_n;
  logic [9:0]  xaddr;
  wire         awready, wready, bvalid, arready, rvalid, halt, fosc, sosc;
  wire         frc8, pgm_we, wkt_run, wdt_run, st_run;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [13:0] xdata, raw, pgm_d;
  wire  [9:0]  pgm_a, dec;
  int          failures = 0;
  int          samples_checked = 0;
  cfgpd_top uut (
    .I_CLOCK(clk), .I_RST_N(rst_n), .I_AWADDR(awaddr), .I_AWVALID(awv),
    .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(4'hF), .I_WVALID(wv),
    .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready),
    .I_ARADDR(araddr), .I_ARVALID(arv), .O_ARREADY(arready), .O_RDATA(rdata),
    .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready),
    .I_PGM_WE(pgm_we), .I_PGM_ADDR(pgm_a), .I_PGM_WDATA(pgm_d),
    .I_EXT_RADDR(xaddr), .I_EXT_RDATA_RAW(raw), .O_EXT_RDATA(xdata),
    .I_SLEEP(sleep), .I_FAST_RC_DIVIDER_SEL(divsel), .I_EXT_IRQ(ext_irq),
    .I_WKT_IRQ(wkt_irq), .I_SLOW_TIMER_IRQ(st_irq),
    .I_SLOW_TIMER_CLOCK_SEL(stcs),
    .I_PA_WAKE_N(pa_n), .I_PB_WAKE_N(pb_n), .O_PROTECT_EN(dec[9]),
    .O_LOW_VOLTAGE_RESET(dec[8]), .O_LOW_VOLTAGE_DETECT(dec[7]),
    .O_LV_LEVEL(dec[6:5]), .O_FAST_CLOCK_TYPE(dec[4]),
    .O_STARTUP_SPEED_SEL(dec[3]), .O_EXT_PIN_RESET_EN(dec[2]),
    .O_WATCHDOG_RESET_EN(dec[1]), .O_FAST_RC_8MHZ(frc8),
    .O_SYSTEM_CLOCK_SEL(dec[0]), .O_CPU_HALT(halt), .O_FAST_OSC_EN(fosc),
    .O_SLOW_OSC_EN(sosc), .O_WAKEUP_TIMER_RUN(wkt_run),
    .O_WATCHDOG_RUN(wdt_run), .O_SLOW_TIMER_RUN(st_run)
  );
  cfgpd_prog_model mem (.i_clock(clk), .i_raddr(xaddr), .o_rdata(raw),
    .o_we(pgm_we), .o_addr(pgm_a), .o_wdata(pgm_d));
  always #10 clk = ~clk;
  task summarize;
    if (failures == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task tmo(input int n);
    if (n >= 40) begin
      failures++;
      $display("[FAIL] %0t no answer", $time);
      summarize();
    end
  endtask
  // handshakes are judged on settled values half a cycle before the edge
  task axw(input logic [31:0] a, d, input logic [1:0] er);
    logic ha, hw, hb;
    logic [1:0] r;
    int n;
    @(posedge clk);
    {awaddr, wdata, awv, wv, bready} <= {a, d, 3'h7};
    for (n = 0; n < 40; n++) begin
      @(negedge clk);
      {ha, hw, hb, r} = {awv & awready, wv & wready, bvalid, bresp};
      @(posedge clk);
      if (ha) awv <= 1'b0;
      if (hw) wv <= 1'b0;
      if (hb) break;
    end
    bready <= 1'b0;
    tmo(n);
    `CHK(r, er)
  endtask
  task axr(input logic [31:0] a, ed, input logic [1:0] er);
    logic ha, hb;
    logic [1:0] r;
    logic [31:0] d;
    int n;
    @(posedge clk);
    {araddr, arv, rready} <= {a, 2'h3};
    for (n = 0; n < 40; n++) begin
      @(negedge clk);
      {ha, hb, r, d} = {arv & arready, rvalid, rresp, rdata};
      @(posedge clk);
      if (ha) arv <= 1'b0;
      if (hb) break;
    end
    rready <= 1'b0;
    tmo(n);
    `CHK(d, ed)
    `CHK(r, er)
  endtask
  task xr(input logic [9:0] a, input logic [13:0] e);
    @(posedge clk);
    xaddr <= a;
    @(posedge clk);
    @(negedge clk);
    `CHK(xdata, e)
  endtask
  task waith(input logic v);
    int n;
    for (n = 0; n < 40; n++) begin
      @(negedge clk);
      if (halt === v) break;
    end
    tmo(n);
  endtask
  initial begin
    clk = 1'b0;
    {awv, wv, bready, arv, rready, sleep, ext_irq, rst_n} = '0;
    {wkt_irq, st_irq, stcs} = '0;
    {awaddr, wdata, araddr, xaddr} = '0;
    {divsel, pa_n, pb_n} = {2'h2, 6'h3F, 3'h7};
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    `CHK(dec, 10'h17E)
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      divsel <= 2'(i);
      @(negedge clk);
      `CHK(frc8, 1'(i == 2))
    end
    axr(32'h18, 32'h3FFF, OK);
    axr(32'h14, 32'h1, OK);
    axr(32'h40, 32'h0, ER);
    axw(32'h40, 32'h1, ER);
    axw(32'h18, 32'h0, ER);
    axr(32'h18, 32'h3FFF, OK);
    axr(32'h10, 32'h0, OK);
    xr(10'h100, {4'hA, 10'h100});
    xr(cfgpd_pkg::CFG_ADDR, 14'h3FFF);
    mem.burn(10'h3FD, 14'h0);
    xr(cfgpd_pkg::CFG_ADDR, 14'h3FFF);
    mem.burn(cfgpd_pkg::CFG_ADDR, 14'h1FE0);
    xr(10'h1FF, cfgpd_pkg::PROT_DATA);
    xr(10'h200, {4'hA, 10'h200});
    mem.burn(10'h200, 14'h2A00);
    mem.burn(10'h201, 14'h2A01);
    mem.burn(cfgpd_pkg::CFG_ADDR, 14'h2FFF);
    xr(cfgpd_pkg::CFG_ADDR, 14'h0FE0);
    xr(10'h200, cfgpd_pkg::PROT_DATA);
    xr(10'h3FB, cfgpd_pkg::PROT_DATA);
    xr(10'h3FD, {4'hA, 10'h3FD});
    // each entry: disabled irqs must not wake, then one source does
    for (int k = 0; k < 5; k++) begin
      axw(32'h14, {29'h0, PD_CTRL[k]}, OK);
      stcs <= (k == 0);
      if (k == 0 || k == 4) begin
        @(posedge clk);
        sleep <= 1'b1;
        @(posedge clk);
        sleep <= 1'b0;
      end else
        axw(32'h0C, k == 1 ? 32'h0 : 32'hA5, OK);
      waith(1'b1);
      `CHK({fosc, sosc, wkt_run, wdt_run, st_run}, PD_RUN[k])
      axr(32'h10, {28'h0, PD_STAT[k]}, OK);
      @(posedge clk);
      {wkt_irq, st_irq} <= PD_DIS[k];
      repeat (5) @(posedge clk);
      @(negedge clk);
      `CHK(halt, 1'b1)
      @(posedge clk);
      {wkt_irq, st_irq} <= {k == 3, k == 4};
      pa_n <= (k == 0) ? 6'h3E : 6'h3F;
      pb_n <= (k == 2) ? 3'h3 : 3'h7;
      ext_irq <= (k == 1);
      waith(1'b0);
      `CHK({fosc, st_run}, 2'h3)
      @(posedge clk);
      {pa_n, pb_n, ext_irq, wkt_irq, st_irq} <= {6'h3F, 3'h7, 3'h0};
      repeat (4) @(posedge clk);
    end
    // new options take effect only at the next reset, and survive it
    mem.burn(cfgpd_pkg::CFG_ADDR, 14'h0440);
    @(posedge clk);
    rst_n <= 1'b0;
    divsel <= 2'h2;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    `CHK(dec, 10'h3A3)
    `CHK(frc8, 1'b0)
    xr(cfgpd_pkg::CFG_ADDR, 14'h0440);
    axr(32'h18, 32'h0440, OK);
    axr(32'h10, 32'h8, OK);
    summarize();
  end
endmodule
